// ==== relay_out_pkg.sv ====
// Purpose: shared constants and types for the motor output relay control
// Assumes: 20 MHz system clock
// Notes: relay vector order is trip, first aux, second aux, alarm
package relay_out_pkg;

  // ----------------------------------------------------------------------
  // relay indices and counts
  // ----------------------------------------------------------------------
  localparam int NUM_RELAYS = 4;
  localparam int NUM_FUNCS = 8;
  localparam int NUM_ELEMS = 8;
  localparam int REL_TRIP = 0;
  localparam int REL_FIRST_AUXILIARY_RELAY = 1;
  localparam int REL_SECOND_AUXILIARY_RELAY = 2;
  localparam int REL_ALARM = 3;

  // block function indices: 37, 46, 48, 49, 50, 51, 51g, 66
  localparam int FN_UC = 0;
  localparam int FN_UNBAL = 1;
  localparam int FN_INCSEQ = 2;
  localparam int FN_THERM = 3;
  localparam int FN_SHORT = 4;
  localparam int FN_OVL = 5;
  localparam int FN_GND = 6;
  localparam int FN_STARTS = 7;

  // ----------------------------------------------------------------------
  // serial command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] FC_FORCE_COIL = 8'h05;
  localparam logic [7:0] CMD_BLOCK = 8'h14;
  localparam logic [3:0] COIL_STOP = 4'h0;
  localparam logic [3:0] COIL_START = 4'h1;
  localparam logic [3:0] COIL_RESET = 4'h2;
  localparam logic [3:0] COIL_CAPTURE = 4'h3;

  // ----------------------------------------------------------------------
  // reset defaults
  // ----------------------------------------------------------------------
  // all sources = 2'b00, remote = 2'b01, local = 2'b10
  localparam logic [1:0] RST_ALL = 2'h0;
  localparam logic [1:0] RST_REMOTE = 2'h1;
  localparam logic [1:0] RST_LOCAL = 2'h2;
  // 1 = fail_safe_polarity; trip defaults fail-safe, others not
  localparam logic [3:0] POL_DEFAULT = 4'h1;
  localparam logic [3:0] START_ASSIGN_DEFAULT = 4'h2;
  localparam logic [7:0] BLOCK_DEFAULT = 8'h00;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int PULSE_MS = 1000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int PULSE_TICKS = PULSE_MS * 1000 / TICK_US;
  localparam int PULSE_W = 10;

  typedef enum logic [1:0] {
    SEL_ALL,
    SEL_REMOTE,
    SEL_LOCAL
  } reset_mode_t;

  // reset request sources, each a one-cycle pulse
  typedef struct packed {
    logic keypad;
    logic digital;
    logic serial;
    logic emergency;
  } reset_req_t;

  // one serial command from the link decoder
  typedef struct packed {
    logic valid;
    logic [7:0] func;
    logic [3:0] coil;
    logic value;
    logic [7:0] block_mask;
  } serial_cmd_t;

  // event record strobe
  typedef struct packed {
    logic valid;
    logic [2:0] func;
    logic blocked;
  } block_event_t;

endpackage

// ==== pulse_timer.sv ====
// Purpose: retriggerable one second pulse from a tick counter
// Assumes: tick is a one-cycle strobe from the system clock prescaler
// Notes: a start during the pulse restarts the full count
`timescale 1ns/1ps
module pulse_timer (
  input wire logic clk,   // system clock
  input wire logic nrst,  // async reset, active low
  input wire logic tick,  // prescaler strobe
  input wire logic start, // begin or restart pulse
  output logic active     // pulse in progress
);

  logic [relay_out_pkg::PULSE_W-1:0] count_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= '0;
    end else if (start) begin
      count_q <= relay_out_pkg::PULSE_W'(relay_out_pkg::PULSE_TICKS);
    end else if (tick && count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign active = (count_q != '0);

endmodule

// ==== relay_out_ctrl.sv ====
// Purpose: output relay control for a motor protection unit
// Assumes: all inputs synchronous to clk; request inputs are pulses
// Notes: protection algorithms live outside; this block gates and drives
//
// Function
// - self-test failure operates the relays assigned to the service role.
// - service, alarm, start assignments take no relay or alarm/aux combos.
// - block functions by serial command 20, serial settings or panel.
// - eight block controls for functions 37..66, default not blocked.
// - blocked function gives no indication, relay action or event.
// - blocking a picked-up function clears its timers to zero.
// - with logging enabled, record each block state change.
// - latched relay reset honoured only once its cause has gone.
// - unlatched element relay releases when its condition clears.
// - per relay reset source: all, remote or local only.
// - latching is set per protection element, not per relay.
// - per relay polarity; trip fail-safe, others non-fail-safe.
// - fail-safe relay energized idle, de-energized when operated.
// - non-fail-safe relay de-energized idle, energized when operated.
// - trip seal-in holds trip until cause cleared and starter open or an allowed reset.
// - seal-in only effective when spare input is starter status.
// - emergency restart resets all latches regardless of reset mode.
// - latched states are volatile and cleared at power-up.
// - remote start/stop accepted only with serial control on, code 5.
// - accepted stop operates trip relay for one second.
// - accepted start operates start relays for one second.
// - serial path also resets relays and triggers waveform capture.
`timescale 1ns/1ps
module relay_out_ctrl (
  input wire logic clk,                          // system clock
  input wire logic nrst,                         // async reset, active low
  // protection element side
  input wire logic [7:0] elem_pickup,            // element operate request
  input wire logic [7:0] elem_latched,           // element latch setting
  input wire logic [31:0] elem_relay_map,        // 4 relay bits per element
  input wire logic [7:0] func_pickup,            // blockable func pickups
  output logic [7:0] func_enable,                // func allowed to act
  output logic [7:0] func_timer_clear,           // clear func timers
  output logic [7:0] func_indicate,              // unblocked pickups
  // self test
  input wire logic selftest_fail,                // diagnostic failure
  input wire logic [3:0] service_relay_assign,   // service relays
  input wire logic [3:0] start_pulse_relay_assignment, // start relays
  // block settings
  input wire logic block_write,                  // panel/settings write
  input wire logic [7:0] block_wdata,            // new block mask
  input wire logic log_block_events,             // block event logging
  output logic [7:0] block_state,                // current block mask
  output relay_out_pkg::block_event_t block_event, // block change event
  // relay settings
  input wire logic [7:0] reset_source_mode,      // 2 bits per relay
  input wire logic [3:0] fail_safe_polarity,     // 1 = fail-safe
  input wire logic trip_hold_until_open,         // trip seal-in enable
  input wire logic spare_input_role,             // 1 = starter status
  input wire logic starter_closed,               // starter status input
  // reset and serial
  input wire relay_out_pkg::reset_req_t reset_req, // reset requests
  input wire logic serial_control_enable,        // serial start/stop ok
  input wire relay_out_pkg::serial_cmd_t serial_cmd, // decoded command
  output logic capture_trigger,                  // waveform capture pulse
  // coil drive
  output logic [3:0] relay_operated,             // logical operated state
  output logic [3:0] coil_energize               // coil drive, 1 = on
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [7:0] block_q;
  logic [7:0] block_d;
  logic [3:0] latch_q;
  logic [3:0] seal_q;
  logic [3:0] cause_any;
  logic [3:0] cause_latched;
  logic [3:0] cause_unlatched;
  logic [3:0] reset_ok;
  logic [3:0] operate;
  logic [3:0] pulse_relays;
  logic [3:0] coil_d;
  logic [3:0] op_d;
  logic [15:0] tick_cnt_q;
  logic tick;
  logic cmd_force;
  logic stop_go;
  logic start_go;
  logic stop_active;
  logic start_active;
  logic serial_reset;
  logic [7:0] ev_pending_q;
  logic [2:0] ev_idx;
  logic ev_found;
  relay_out_pkg::reset_req_t reset_src;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // limit an assignment to alarm and the two auxiliaries
  function automatic logic [3:0] aux_alarm_only(input logic [3:0] a);
    aux_alarm_only = a & 4'hE;
  endfunction

  // whether a relay honours the present reset requests
  function automatic logic reset_allowed(
    input logic [1:0] mode,
    input relay_out_pkg::reset_req_t r
  );
    logic remote;
    remote = r.digital | r.serial;
    case (mode)
      relay_out_pkg::RST_REMOTE: reset_allowed = remote;
      relay_out_pkg::RST_LOCAL: reset_allowed = r.keypad;
      default: reset_allowed = remote | r.keypad;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // serial command decode
  // ----------------------------------------------------------------------
  assign cmd_force = serial_cmd.valid &&
    serial_cmd.func == relay_out_pkg::FC_FORCE_COIL && serial_cmd.value;
  assign stop_go = cmd_force && serial_control_enable &&
    serial_cmd.coil == relay_out_pkg::COIL_STOP;
  assign start_go = cmd_force && serial_control_enable &&
    serial_cmd.coil == relay_out_pkg::COIL_START;
  assign serial_reset = cmd_force &&
    serial_cmd.coil == relay_out_pkg::COIL_RESET;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      capture_trigger <= 1'b0;
    end else begin
      capture_trigger <= cmd_force &&
        serial_cmd.coil == relay_out_pkg::COIL_CAPTURE;
    end
  end

  // ----------------------------------------------------------------------
  // block controls
  // ----------------------------------------------------------------------
  always_comb begin
    block_d = block_q;
    if (serial_cmd.valid && serial_cmd.func == relay_out_pkg::CMD_BLOCK) begin
      block_d = serial_cmd.block_mask;
    end else if (block_write) begin
      block_d = block_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      block_q <= relay_out_pkg::BLOCK_DEFAULT;
    end else begin
      block_q <= block_d;
    end
  end

  assign block_state = block_q;
  assign func_enable = ~block_q;
  assign func_indicate = func_pickup & ~block_q;

  // one-cycle clear when a function becomes blocked
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      func_timer_clear <= '0;
    end else begin
      func_timer_clear <= block_d & ~block_q;
    end
  end

  // ----------------------------------------------------------------------
  // block change events
  // ----------------------------------------------------------------------
  // changes are queued per function so simultaneous edits are all logged
  always_comb begin
    ev_idx = '0;
    ev_found = 1'b0;
    for (int i = relay_out_pkg::NUM_FUNCS - 1; i >= 0; i--) begin
      if (ev_pending_q[i]) begin
        ev_idx = 3'(i);
        ev_found = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ev_pending_q <= '0;
    end else begin
      // a new change wins over the clear of the one just reported
      ev_pending_q <= (ev_pending_q &
        ~(ev_found ? (8'h01 << ev_idx) : 8'h00)) |
        (log_block_events ? (block_d ^ block_q) : 8'h00);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      block_event <= '0;
    end else begin
      block_event.valid <= ev_found;
      block_event.func <= ev_idx;
      block_event.blocked <= block_q[ev_idx];
    end
  end

  // ----------------------------------------------------------------------
  // element to relay mapping
  // ----------------------------------------------------------------------
  // elements arrive already gated by func_enable, so blocked ones are quiet
  always_comb begin
    cause_latched = '0;
    cause_unlatched = '0;
    for (int e = 0; e < relay_out_pkg::NUM_ELEMS; e++) begin
      if (elem_pickup[e]) begin
        if (elem_latched[e]) begin
          cause_latched = cause_latched | elem_relay_map[e*4 +: 4];
        end else begin
          cause_unlatched = cause_unlatched | elem_relay_map[e*4 +: 4];
        end
      end
    end
  end

  assign cause_any = cause_latched | cause_unlatched;

  always_comb begin
    // a coil reset is a remote reset
    reset_src = reset_req;
    reset_src.serial = reset_req.serial | serial_reset;
    for (int r = 0; r < relay_out_pkg::NUM_RELAYS; r++) begin
      reset_ok[r] = reset_allowed(reset_source_mode[r*2 +: 2], reset_src) |
        reset_req.emergency;
    end
  end

  // ----------------------------------------------------------------------
  // latches
  // ----------------------------------------------------------------------
  // cleared by an allowed reset once the cause is gone, or by power-on reset; nothing survives a power cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch_q <= '0;
    end else begin
      for (int r = 0; r < relay_out_pkg::NUM_RELAYS; r++) begin
        if (cause_latched[r]) begin
          latch_q[r] <= 1'b1;
        end else if (reset_ok[r] && !cause_any[r]) begin
          latch_q[r] <= 1'b0;
        end
      end
    end
  end

  // trip seal-in: hold until cause gone, then starter open or an allowed reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seal_q <= '0;
    end else begin
      seal_q[3:1] <= '0;
      if (!(trip_hold_until_open && spare_input_role)) begin
        seal_q[relay_out_pkg::REL_TRIP] <= 1'b0;
      end else if (cause_any[relay_out_pkg::REL_TRIP]) begin
        seal_q[relay_out_pkg::REL_TRIP] <= 1'b1;
      end else if (reset_ok[relay_out_pkg::REL_TRIP] ||
                   !starter_closed) begin
        seal_q[relay_out_pkg::REL_TRIP] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // serial start and stop pulses
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  assign tick = (tick_cnt_q ==
    16'(relay_out_pkg::TICK_CYCLES - 1));

  pulse_timer stop_timer (
    .clk(clk),
    .nrst(nrst),
    .tick(tick),
    .start(stop_go),
    .active(stop_active)
  );

  pulse_timer start_timer (
    .clk(clk),
    .nrst(nrst),
    .tick(tick),
    .start(start_go),
    .active(start_active)
  );

  always_comb begin
    pulse_relays = '0;
    pulse_relays[relay_out_pkg::REL_TRIP] = stop_active;
    if (start_active) begin
      pulse_relays = pulse_relays |
        aux_alarm_only(start_pulse_relay_assignment);
    end
  end

  // ----------------------------------------------------------------------
  // coil drive
  // ----------------------------------------------------------------------
  always_comb begin
    operate = cause_unlatched | latch_q | seal_q | pulse_relays;
    if (selftest_fail) begin
      operate = operate | aux_alarm_only(service_relay_assign);
    end
    op_d = operate;
    for (int r = 0; r < relay_out_pkg::NUM_RELAYS; r++) begin
      if (fail_safe_polarity[r]) begin
        coil_d[r] = ~operate[r];
      end else begin
        coil_d[r] = operate[r];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      relay_operated <= '0;
      coil_energize <= relay_out_pkg::POL_DEFAULT;
    end else begin
      relay_operated <= op_d;
      coil_energize <= coil_d;
    end
  end

endmodule

// ==== serial_master_model.sv ====
// Purpose: serial master model issuing decoded force-coil and block commands
// Assumes: send is held for exactly one cycle by the bench
// Notes: payload is inverted while idle so stale fields never look valid
`timescale 1ns/1ps
module serial_master_model (
  input wire logic clk, // system clock
  input wire logic send, // issue one command
  input wire logic blk, // 1 = block command instead of coil write
  input wire logic [3:0] coil, // coil code
  input wire logic [7:0] mask, // block mask payload
  output relay_out_pkg::serial_cmd_t cmd // command into the block
);
  initial cmd = '0;
  // changes just after the edge, one cycle per command
  always @(posedge clk) begin
    if (send) begin
      cmd.valid <= 1'b1;
      cmd.func <= blk ? relay_out_pkg::CMD_BLOCK
                      : relay_out_pkg::FC_FORCE_COIL;
      cmd.coil <= coil;
      cmd.value <= 1'b1;
      cmd.block_mask <= mask;
    end else begin
      cmd <= {1'b0, ~cmd[20:0]};
    end
  end
endmodule

// ==== relay_out_ctrl_properties.sv ====
// Purpose: concurrent checks on the relay control ports
// Assumes: one clock domain, nrst async active low
// Notes: the one second pulse end is too long to bound here
`timescale 1ns/1ps
module relay_out_ctrl_properties (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset
  input wire logic [7:0] func_pickup, // raw pickups
  input wire logic [7:0] func_enable, // allowed functions
  input wire logic [7:0] func_indicate, // unblocked pickups
  input wire logic [7:0] func_timer_clear, // timer clear pulse
  input wire logic block_write, // block load
  input wire logic [7:0] block_wdata, // new mask
  input wire logic log_block_events, // logging on
  input wire logic [7:0] block_state, // block mask
  input wire relay_out_pkg::block_event_t block_event, // event strobe
  input wire logic [3:0] fail_safe_polarity, // polarity
  input wire logic serial_control_enable, // serial start/stop ok
  input wire relay_out_pkg::serial_cmd_t serial_cmd, // command
  input wire logic capture_trigger, // capture pulse
  input wire logic [3:0] relay_operated, // operated state
  input wire logic [3:0] coil_energize // coil drive
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic coil_cmd;
  logic blk_cmd;
  assign coil_cmd = serial_cmd.valid && serial_cmd.value &&
    serial_cmd.func == relay_out_pkg::FC_FORCE_COIL;
  assign blk_cmd = serial_cmd.valid &&
    serial_cmd.func == relay_out_pkg::CMD_BLOCK;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_en; func_enable == ~block_state; endproperty
  a_en: assert property (p_en)
    else $error("enable not inverse of block mask");
  property p_ind; func_indicate == (func_pickup & ~block_state); endproperty
  a_ind: assert property (p_ind)
    else $error("blocked pickup indicated");
  property p_clr;
    func_timer_clear == (block_state & ~$past(block_state));
  endproperty
  a_clr: assert property (p_clr)
    else $error("timer clear not on newly blocked bits");
  property p_nolog;
    !$past(log_block_events) && !$past(log_block_events, 2)
      |-> !block_event.valid;
  endproperty
  a_nolog: assert property (p_nolog)
    else $error("event while logging off");
  property p_wr;
    block_write && !blk_cmd |=> block_state == $past(block_wdata);
  endproperty
  a_wr: assert property (p_wr)
    else $error("block write not loaded");
  property p_ser;
    blk_cmd |=> block_state == $past(serial_cmd.block_mask);
  endproperty
  a_ser: assert property (p_ser)
    else $error("serial block not loaded");
  property p_hold; !block_write && !blk_cmd |=> $stable(block_state);
  endproperty
  a_hold: assert property (p_hold)
    else $error("block mask changed without request");
  property p_pol;
    coil_energize == (relay_operated ^ $past(fail_safe_polarity));
  endproperty
  a_pol: assert property (p_pol)
    else $error("coil drive does not follow polarity");
  property p_cap;
    capture_trigger == $past(coil_cmd &&
      serial_cmd.coil == relay_out_pkg::COIL_CAPTURE);
  endproperty
  a_cap: assert property (p_cap)
    else $error("capture pulse mismatch");
  // three cycles covers both readings of the two stage pulse path
  property p_stop;
    coil_cmd && serial_cmd.coil == relay_out_pkg::COIL_STOP &&
      serial_control_enable |-> ##3 relay_operated[0];
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not operate trip");
  c_ev: cover property (block_event.valid);
  c_cap: cover property (capture_trigger);
  c_trip: cover property (relay_operated[0] && !coil_energize[0]);
endmodule

bind relay_out_ctrl relay_out_ctrl_properties relay_out_ctrl_properties_i (
  .clk(clk), .nrst(nrst), .func_pickup(func_pickup),
  .func_enable(func_enable), .func_indicate(func_indicate),
  .func_timer_clear(func_timer_clear), .block_write(block_write),
  .block_wdata(block_wdata), .log_block_events(log_block_events),
  .block_state(block_state), .block_event(block_event),
  .fail_safe_polarity(fail_safe_polarity),
  .serial_control_enable(serial_control_enable), .serial_cmd(serial_cmd),
  .capture_trigger(capture_trigger), .relay_operated(relay_operated),
  .coil_energize(coil_energize));

// ==== tb_relay_out_ctrl.sv ====
// Purpose: self-checking bench for the output relay control
// Assumes: inputs change on the falling edge
// Notes: the full one second pulse is too long to run out here
`timescale 1ns/1ps
module tb_relay_out_ctrl;
  logic clk;
  logic nrst = 1'b0;
  logic [7:0] elem_pickup = '0, elem_latched = '0, func_pickup = '0;
  logic [7:0] block_wdata = '0, reset_source_mode = '0;
  logic [31:0] elem_relay_map = '0;
  logic selftest_fail = 0, block_write = 0, log_block_events = 0;
  logic trip_hold_until_open = 0, spare_input_role = 0;
  logic starter_closed = 0, serial_control_enable = 0;
  logic [3:0] service_relay_assign = '0, fail_safe_polarity = 4'h1;
  logic [3:0] start_pulse_relay_assignment = 4'h2;
  relay_out_pkg::reset_req_t reset_req = '0;
  relay_out_pkg::serial_cmd_t serial_cmd;
  relay_out_pkg::block_event_t block_event;
  logic [7:0] func_enable, func_timer_clear, func_indicate, block_state;
  logic capture_trigger;
  logic [3:0] relay_operated, coil_energize;
  logic send = 0, blk = 0;
  logic [3:0] coil = '0;
  logic [7:0] mask = '0;
  int errors = 0;
  int num_checks = 0;

  relay_out_ctrl relay_out_ctrl_i (.clk, .nrst, .elem_pickup, .elem_latched,
    .elem_relay_map, .func_pickup, .func_enable, .func_timer_clear,
    .func_indicate, .selftest_fail, .service_relay_assign,
    .start_pulse_relay_assignment, .block_write, .block_wdata,
    .log_block_events, .block_state, .block_event, .reset_source_mode,
    .fail_safe_polarity, .trip_hold_until_open, .spare_input_role,
    .starter_closed, .reset_req, .serial_control_enable, .serial_cmd,
    .capture_trigger, .relay_operated, .coil_energize);
  serial_master_model serial_master_model_i (.clk, .send, .blk, .coil,
    .mask, .cmd(serial_cmd));

  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic rst(input logic [3:0] r);
    reset_req = relay_out_pkg::reset_req_t'(r);
    cyc(1);
    reset_req = '0;
    cyc(1);
  endtask
  task automatic latch1();
    elem_pickup = 8'h02;
    cyc(1);
    elem_pickup = 8'h00;
    cyc(1);
  endtask
  task automatic ser(input logic b, input logic [3:0] c, input logic [7:0] k);
    send = 1;
    blk = b;
    coil = c;
    mask = k;
    cyc(1);
    send = 0;
  endtask
  task automatic ev(output logic [7:0] s);
    s = '0;
    repeat (4) begin
      cyc(1);
      if (block_event.valid === 1'b1) s = {s[3:0], block_event[3:0]};
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(coil_energize, 4'h1, "reset coil");
    chk(relay_operated, 4'h0, "reset relays");
    chk(func_enable, 8'hFF, "reset enable");
    $display("test reset done");
  endtask
  task automatic t_pol();
    logic [3:0] p;
    elem_relay_map = 32'h0000000F;
    for (int i = 0; i < 2; i++) begin
      p = i ? 4'hA : 4'h1;
      fail_safe_polarity = p;
      cyc(1);
      chk(coil_energize, p, "idle coil");
      elem_pickup = 8'h01;
      cyc(1);
      chk(coil_energize, 4'(~p), "active coil");
      elem_pickup = 8'h00;
      cyc(1);
      chk(relay_operated, 4'h0, "self release");
    end
    fail_safe_polarity = 4'h1;
    $display("test polarity done");
  endtask
  task automatic t_latch();
    elem_latched = 8'h02;
    elem_relay_map = 32'h000000FF;
    reset_source_mode = 8'h06;
    elem_pickup = 8'h01;
    cyc(1);
    elem_pickup = 8'h02;
    cyc(1);
    rst(4'h8);
    chk(relay_operated, 4'hF, "reset with cause");
    elem_pickup = 8'h00;
    rst(4'h8);
    chk(relay_operated, 4'h2, "keypad reset");
    rst(4'h4);
    chk(relay_operated, 4'h0, "digital reset");
    latch1();
    reset_source_mode = 8'hAA;
    rst(4'h4);
    chk(relay_operated, 4'hF, "remote refused");
    rst(4'h1);
    chk(relay_operated, 4'h0, "emergency");
    latch1();
    nrst = 0;
    cyc(1);
    nrst = 1;
    cyc(1);
    chk(relay_operated, 4'h0, "power loss");
    reset_source_mode = 8'h00;
    $display("test latch done");
  endtask
  task automatic t_block();
    logic [7:0] s;
    log_block_events = 1;
    func_pickup = 8'hFF;
    block_write = 1;
    block_wdata = 8'h81;
    cyc(1);
    block_write = 0;
    chk(func_indicate, 8'h7E, "indicate");
    chk(func_timer_clear, 8'h81, "timer clear");
    ev(s);
    chk(s, 8'h1F, "block events");
    ser(1, 4'h0, 8'h01);
    cyc(1);
    chk(block_state, 8'h01, "serial block");
    ev(s);
    chk(s, 8'h0E, "unblock event");
    log_block_events = 0;
    block_write = 1;
    block_wdata = 8'h00;
    cyc(1);
    block_write = 0;
    ev(s);
    chk(s, 8'h00, "logging off");
    $display("test block done");
  endtask
  task automatic t_seal();
    elem_latched = 8'h00;
    elem_relay_map = 32'h00000001;
    trip_hold_until_open = 1;
    for (int i = 0; i < 2; i++) begin
      spare_input_role = !i;
      starter_closed = 1;
      elem_pickup = 8'h01;
      cyc(1);
      elem_pickup = 8'h00;
      cyc(3);
      chk(relay_operated, !i, "seal hold");
      starter_closed = 0;
      cyc(3);
      chk(relay_operated, 4'h0, "seal open");
    end
    trip_hold_until_open = 0;
    $display("test seal done");
  endtask
  task automatic t_self();
    service_relay_assign = 4'hF;
    selftest_fail = 1;
    cyc(2);
    chk(relay_operated, 4'hE, "service relays");
    selftest_fail = 0;
    cyc(2);
    rst(4'h1);
    $display("test selftest done");
  endtask
  task automatic t_serial();
    elem_latched = 8'h02;
    elem_relay_map = 32'h000000F0;
    ser(0, relay_out_pkg::COIL_START, 8'h00);
    cyc(3);
    chk(relay_operated, 4'h0, "start disabled");
    ser(0, relay_out_pkg::COIL_CAPTURE, 8'h00);
    cyc(1);
    chk(capture_trigger, 1'b1, "capture");
    latch1();
    ser(0, relay_out_pkg::COIL_RESET, 8'h00);
    cyc(2);
    chk(relay_operated, 4'h0, "serial reset");
    serial_control_enable = 1;
    start_pulse_relay_assignment = 4'h7;
    ser(0, relay_out_pkg::COIL_START, 8'h00);
    cyc(3);
    chk(relay_operated, 4'h6, "start pulse");
    cyc(2000);
    chk(relay_operated, 4'h6, "start held");
    ser(0, relay_out_pkg::COIL_STOP, 8'h00);
    cyc(3);
    chk(coil_energize, 4'h6, "stop trips");
    $display("test serial done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    cyc(2);
    nrst = 1;
    cyc(1);
    t_reset();
    t_pol();
    t_latch();
    t_block();
    t_seal();
    t_self();
    t_serial();
    end_sim();
  end
endmodule
